// [ibg_flash_guard.sv]
/*
 * Device end: boot-region selection, software reset and flash guard.
 * Assumes option inputs are static levels on SYS_CLK, the flash engine
 * answers FL_REQ with a one-cycle FL_DONE, and the core side is ibg_if.
 */
// Register access over Wishbone and the register offsets are this design's own decisions.
`default_nettype none
module ibg_flash_guard
    import ibg_pkg::*;
#(
    parameter int SW_RST_CYCLES = SW_RST_LEN
) (
    input wire logic SYS_CLK,
    input wire logic NRST,
    input wire logic EXT_RST_N,
    input wire logic HW_BOOT_LOADER_OPTION,
    input wire logic HW_BOOT_ON_EXT_RESET_OPTION,
    input wire logic [ADDR_W-1:0] LOADER_START,
    input wire logic [ADDR_W-1:0] IAP_LOW,
    output logic FL_REQ,
    output logic [1:0] FL_OP,
    output logic [ADDR_W-1:0] FL_ADDR,
    output logic [7:0] FL_WDATA,
    input wire logic [7:0] FL_RDATA,
    input wire logic FL_DONE,
    ibg_if.dev bus
);
    localparam int CNT_W = $clog2(SW_RST_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(SW_RST_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    typedef enum logic [4:0] {
        ST_START = 5'h01,
        ST_RUN = 5'h02,
        ST_FLASH = 5'h04,
        ST_SW_RESET_TRIGGER = 5'h08,
        ST_EXTRST = 5'h10
    } ibg_state_t;
    ibg_state_t st_ff;
    ibg_state_t nxt_st;
    logic ext_meta_ff;
    logic ext_sync_ff;
    logic hw_boot_loader_option_ff;
    logic hw_boot_on_ext_reset_option_ff;
    logic [ADDR_W-1:0] ldr_start_ff;
    logic [ADDR_W-1:0] iap_low_ff;
    logic boot_ldr_ff;
    logic [7:0] ctl_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic req_ff;
    logic [1:0] op_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [7:0] wdata_ff;
    logic [7:0] rdata_ff;
    logic ign_ff;
    logic rst_out_ff;
    logic halt_ff;
    logic [ADDR_W-1:0] phys_ff;
    logic [IRQ_N-1:0] take_ff;
    logic ldr_valid;
    logic [ADDR_W-1:0] iap_high;
    logic mode_ok;
    logic addr_ok;
    logic trig_ok;
    logic sw_rst_req;
    // External reset pin synchroniser
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            ext_meta_ff <= 1'b1;
            ext_sync_ff <= 1'b1;
        end else begin
            ext_meta_ff <= EXT_RST_N;
            ext_sync_ff <= ext_meta_ff;
        end
    end
    // Options caught in the first cycle after power-on release
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            hw_boot_loader_option_ff <= 1'b0;
            hw_boot_on_ext_reset_option_ff <= 1'b0;
            ldr_start_ff <= FLASH_LAST;
            iap_low_ff <= FLASH_LAST;
        end else if (st_ff == ST_START) begin
            hw_boot_loader_option_ff <= HW_BOOT_LOADER_OPTION;
            hw_boot_on_ext_reset_option_ff <= HW_BOOT_ON_EXT_RESET_OPTION;
            ldr_start_ff <= LOADER_START;
            iap_low_ff <= IAP_LOW;
        end
    end
    // No loader when its start lies past the flash end or at zero
    assign ldr_valid = (ldr_start_ff <= FLASH_LAST) &&
                       (ldr_start_ff != APP_VECTOR);
    assign iap_high = ldr_valid ? ldr_start_ff - 14'h0001 : FLASH_LAST;
    assign sw_rst_req = bus.ctl_wr && bus.ctl_wdata[CTL_TRIG_BIT];
    always_comb begin
        unique case (bus.op_mode)
            MODE_READ, MODE_PROGRAM, MODE_ERASE: mode_ok = 1'b1;
            default: mode_ok = 1'b0;
        endcase
    end
    // Loader may reach app and data regions, app only the data region
    assign addr_ok = (bus.op_addr <= iap_high) &&
                     (boot_ldr_ff || bus.op_addr >= iap_low_ff);
    assign trig_ok = ctl_ff[CTL_EN_BIT] && mode_ok && addr_ok;
    always_comb begin
        nxt_st = st_ff;
        unique case (st_ff)
            ST_START: nxt_st = ST_RUN;
            ST_RUN: begin
                if (!ext_sync_ff) begin
                    nxt_st = ST_EXTRST;
                end else if (sw_rst_req) begin
                    nxt_st = ST_SW_RESET_TRIGGER;
                end else if (bus.op_trig && trig_ok) begin
                    nxt_st = ST_FLASH;
                end
            end
            ST_FLASH: begin
                if (FL_DONE) begin
                    nxt_st = ST_RUN;
                end
            end
            ST_SW_RESET_TRIGGER: begin
                if (cnt_ff == CNT_ZERO) begin
                    nxt_st = ST_RUN;
                end
            end
            ST_EXTRST: begin
                if (ext_sync_ff) begin
                    nxt_st = ST_RUN;
                end
            end
            default: nxt_st = ST_START;
        endcase
    end
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            st_ff <= ST_START;
        end else begin
            st_ff <= nxt_st;
        end
    end
    // Boot region: picked at power-on, external reset end, soft reset
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            boot_ldr_ff <= 1'b0;
        end else if (st_ff == ST_START) begin
            boot_ldr_ff <= HW_BOOT_LOADER_OPTION &&
                           (LOADER_START <= FLASH_LAST) &&
                           (LOADER_START != APP_VECTOR);
        end else if (st_ff == ST_EXTRST && ext_sync_ff) begin
            boot_ldr_ff <= hw_boot_loader_option_ff && hw_boot_on_ext_reset_option_ff && ldr_valid;
        end else if (st_ff == ST_RUN && ext_sync_ff && sw_rst_req) begin
            boot_ldr_ff <= bus.ctl_wdata[CTL_BOOT_BIT] && ldr_valid;
        end
    end
    // Control register; trigger bit never stored, cleared on any reset
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            ctl_ff <= CTL_RESET;
        end else if (nxt_st == ST_SW_RESET_TRIGGER || nxt_st == ST_EXTRST) begin
            ctl_ff <= CTL_RESET;
        end else if (st_ff == ST_RUN && bus.ctl_wr) begin
            ctl_ff <= bus.ctl_wdata & ~(8'h01 << CTL_TRIG_BIT);
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            cnt_ff <= CNT_ZERO;
        end else if (nxt_st == ST_SW_RESET_TRIGGER && st_ff != ST_SW_RESET_TRIGGER) begin
            cnt_ff <= CNT_LOAD;
        end else if (cnt_ff != CNT_ZERO) begin
            cnt_ff <= cnt_ff - CNT_W'(1);
        end
    end
    // Flash engine request, held until the engine reports done
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            req_ff <= 1'b0;
            op_ff <= 2'b00;
            addr_ff <= APP_VECTOR;
            wdata_ff <= 8'h00;
        end else if (st_ff == ST_RUN && nxt_st == ST_FLASH) begin
            req_ff <= 1'b1;
            op_ff <= bus.op_mode[1:0];
            addr_ff <= bus.op_addr;
            wdata_ff <= bus.op_wdata;
        end else if (FL_DONE) begin
            req_ff <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            rdata_ff <= 8'hff;
        end else if (st_ff == ST_FLASH && FL_DONE &&
                     op_ff == MODE_READ[1:0]) begin
            rdata_ff <= FL_RDATA;
        end
    end
    // Refused trigger: flash untouched, one-cycle flag to the core
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            ign_ff <= 1'b0;
        end else begin
            ign_ff <= st_ff == ST_RUN && ext_sync_ff && !sw_rst_req &&
                      bus.op_trig && !trig_ok;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            rst_out_ff <= 1'b1;
            halt_ff <= 1'b0;
        end else begin
            rst_out_ff <= nxt_st == ST_SW_RESET_TRIGGER || nxt_st == ST_EXTRST ||
                          nxt_st == ST_START;
            halt_ff <= nxt_st == ST_FLASH;
        end
    end
    // Loader code is linked at zero; add the region start on fetch
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            phys_ff <= APP_VECTOR;
        end else if (boot_ldr_ff) begin
            phys_ff <= bus.fetch_addr + ldr_start_ff;
        end else begin
            phys_ff <= bus.fetch_addr;
        end
    end
    // Interrupts pass only while running; held flags go out after op
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            take_ff <= '0;
        end else if (nxt_st == ST_RUN && st_ff != ST_START) begin
            take_ff <= bus.irq_flag;
        end else begin
            take_ff <= '0;
        end
    end
    assign FL_REQ = req_ff;
    assign FL_OP = op_ff;
    assign FL_ADDR = addr_ff;
    assign FL_WDATA = wdata_ff;
    assign bus.ctl_rdata = ctl_ff;
    assign bus.op_rdata = rdata_ff;
    assign bus.op_ignored = ign_ff;
    assign bus.core_halt = halt_ff;
    assign bus.core_rst = rst_out_ff;
    assign bus.boot_loader = boot_ldr_ff;
    assign bus.fetch_phys = phys_ff;
    assign bus.irq_take = take_ff;
endmodule
`default_nettype wire

// [ibg_pkg.sv]
/*
 * Shared constants for the boot-select and flash-guard block and its
 * core-side partner.
 * Assumes one system clock shared by both ends.
 */
`default_nettype none
package ibg_pkg;
    localparam int ADDR_W = 14;
    localparam logic [ADDR_W-1:0] FLASH_LAST = 14'h3dff;
    localparam logic [ADDR_W-1:0] APP_VECTOR = 14'h0000;
    // Control register fields
    localparam int CTL_EN_BIT = 7;
    localparam int CTL_BOOT_BIT = 6;
    localparam int CTL_TRIG_BIT = 5;
    localparam logic [7:0] CTL_RESET = 8'h00;
    // Flash operation mode field
    localparam int MODE_W = 5;
    localparam logic [MODE_W-1:0] MODE_STANDBY = 5'h00;
    localparam logic [MODE_W-1:0] MODE_READ = 5'h01;
    localparam logic [MODE_W-1:0] MODE_PROGRAM = 5'h02;
    localparam logic [MODE_W-1:0] MODE_ERASE = 5'h03;
    // Core held in reset this many cycles after a software reset
    localparam int SW_RST_LEN = 4;
    localparam int IRQ_N = 2;
    // Core-side register map, byte addresses
    localparam logic [7:0] REG_CTL = 8'h00;
    localparam logic [7:0] REG_MODE = 8'h04;
    localparam logic [7:0] REG_ADDR = 8'h08;
    localparam logic [7:0] REG_DATA = 8'h0c;
    localparam logic [7:0] REG_TRIG = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam logic [7:0] REG_FETCH = 8'h18;
    localparam logic [7:0] REG_IRQ = 8'h1c;
    localparam int ST_IGN_BIT = 3;
endpackage
`default_nettype wire

// [ibg_if.sv]
/*
 * Link between the flash guard and the processor core side.
 * Assumes both ends run on the same clock; no clocking block.
 */
`default_nettype none
interface ibg_if;
    import ibg_pkg::*;
    logic ctl_wr;
    logic [7:0] ctl_wdata;
    logic [7:0] ctl_rdata;
    logic [MODE_W-1:0] op_mode;
    logic [ADDR_W-1:0] op_addr;
    logic [7:0] op_wdata;
    logic op_trig;
    logic [7:0] op_rdata;
    logic op_ignored;
    logic core_halt;
    logic core_rst;
    logic boot_loader;
    logic [ADDR_W-1:0] fetch_addr;
    logic [ADDR_W-1:0] fetch_phys;
    logic [IRQ_N-1:0] irq_flag;
    logic [IRQ_N-1:0] irq_take;
    modport dev (input ctl_wr, ctl_wdata, op_mode, op_addr, op_wdata,
        op_trig, fetch_addr, irq_flag, output ctl_rdata, op_rdata,
        op_ignored, core_halt, core_rst, boot_loader, fetch_phys, irq_take);
    modport core (output ctl_wr, ctl_wdata, op_mode, op_addr, op_wdata,
        op_trig, fetch_addr, irq_flag, input ctl_rdata, op_rdata,
        op_ignored, core_halt, core_rst, boot_loader, fetch_phys, irq_take);
endinterface
`default_nettype wire

// [ibg_core_port.sv]
/*
 * Core end: software drives the flash guard through a classic
 * Wishbone slave. Assumes one clock shared with the flash guard.
 */
`default_nettype none
module ibg_core_port
    import ibg_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic NRST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    ibg_if.core bus
);
    logic ack_ff;
    logic [31:0] dat_ff;
    logic ctl_wr_ff;
    logic [7:0] ctl_ff;
    logic [MODE_W-1:0] mode_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [7:0] wdata_ff;
    logic trig_ff;
    logic ign_ff;
    logic [ADDR_W-1:0] fetch_ff;
    logic [IRQ_N-1:0] irq_ff;
    logic req;
    logic stall;
    logic wr;
    logic [31:0] rd;

    assign req = WB_CYC_I && WB_STB_I;
    // A frozen or resetting core issues nothing
    assign stall = bus.core_halt || bus.core_rst;
    assign wr = req && WB_WE_I && ack_ff;

    always_comb begin
        rd = 32'h0000_0000;
        unique case (WB_ADR_I)
            REG_CTL: rd[7:0] = bus.ctl_rdata;
            REG_MODE: rd[MODE_W-1:0] = mode_ff;
            REG_ADDR: rd[ADDR_W-1:0] = addr_ff;
            REG_DATA: rd[7:0] = bus.op_rdata;
            REG_STATUS: rd[ST_IGN_BIT:0] = {ign_ff, bus.boot_loader,
                                            bus.core_rst, bus.core_halt};
            REG_FETCH: rd[ADDR_W-1:0] = bus.fetch_phys;
            REG_IRQ: rd[IRQ_N-1:0] = bus.irq_take;
            default: rd = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= req && !ack_ff && !stall;
            dat_ff <= rd;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            ctl_wr_ff <= 1'b0;
            ctl_ff <= CTL_RESET;
            trig_ff <= 1'b0;
        end else begin
            ctl_wr_ff <= wr && WB_ADR_I == REG_CTL && WB_SEL_I[0];
            ctl_ff <= WB_DAT_I[7:0];
            trig_ff <= wr && WB_ADR_I == REG_TRIG;
        end
    end

    // Mode, address, data, fetch and interrupt registers start over with every core reset
    always_ff @(posedge SYS_CLK) begin
        if (!NRST || bus.core_rst) begin
            mode_ff <= MODE_STANDBY;
            addr_ff <= APP_VECTOR;
            wdata_ff <= 8'hff;
            fetch_ff <= APP_VECTOR;
            irq_ff <= '0;
        end else if (wr && WB_SEL_I[0]) begin
            if (WB_ADR_I == REG_MODE) begin
                mode_ff <= WB_DAT_I[MODE_W-1:0];
            end
            if (WB_ADR_I == REG_ADDR && WB_SEL_I[1]) begin
                addr_ff <= WB_DAT_I[ADDR_W-1:0];
            end
            if (WB_ADR_I == REG_DATA) begin
                wdata_ff <= WB_DAT_I[7:0];
            end
            if (WB_ADR_I == REG_FETCH && WB_SEL_I[1]) begin
                fetch_ff <= WB_DAT_I[ADDR_W-1:0];
            end
            if (WB_ADR_I == REG_IRQ) begin
                irq_ff <= WB_DAT_I[IRQ_N-1:0];
            end
        end
    end

    // Sticky refusal flag; a new refusal wins over the clear
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            ign_ff <= 1'b0;
        end else if (bus.op_ignored) begin
            ign_ff <= 1'b1;
        end else if (wr && WB_ADR_I == REG_STATUS && WB_SEL_I[0] &&
                     WB_DAT_I[ST_IGN_BIT]) begin
            ign_ff <= 1'b0;
        end
    end

    assign WB_ACK_O = ack_ff;
    assign WB_DAT_O = dat_ff;
    assign bus.ctl_wr = ctl_wr_ff;
    assign bus.ctl_wdata = ctl_ff;
    assign bus.op_mode = mode_ff;
    assign bus.op_addr = addr_ff;
    assign bus.op_wdata = wdata_ff;
    assign bus.op_trig = trig_ff;
    assign bus.fetch_addr = fetch_ff;
    assign bus.irq_flag = irq_ff;
endmodule
`default_nettype wire

// [ibg_link_sva.sv]
/* Assertions on the guard-to-core link signals.
   Assumes one clock and the default soft-reset length of 4. */
`default_nettype none
module ibg_link_sva
    import ibg_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic NRST,
    input wire logic ctl_wr,
    input wire logic [7:0] ctl_wdata,
    input wire logic [7:0] ctl_rdata,
    input wire logic op_trig,
    input wire logic op_ignored,
    input wire logic core_halt,
    input wire logic core_rst,
    input wire logic boot_loader,
    input wire logic [ADDR_W-1:0] fetch_addr,
    input wire logic [ADDR_W-1:0] fetch_phys,
    input wire logic [IRQ_N-1:0] irq_flag,
    input wire logic [IRQ_N-1:0] irq_take
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);
    a_trig_answer: assert property (
        op_trig |=> core_halt != op_ignored)
        else $error("trigger neither run nor refused");
    a_sw_reset_trigger_hold: assert property (
        ctl_wr && ctl_wdata[CTL_TRIG_BIT] |=> core_rst [*4] ##1 !core_rst)
        else $error("soft reset length wrong");
    a_app_region: assert property (
        ctl_wr && ctl_wdata[6:5] == 2'b01 |=> !boot_loader)
        else $error("reboot not into application");
    a_halt_queue: assert property (
        core_halt && $past(core_halt) |-> irq_take == '0)
        else $error("interrupt passed while halted");
    a_resume_irq: assert property (
        $fell(core_halt) && !core_rst |-> irq_take == irq_flag)
        else $error("queued interrupt not passed on resume");
    a_ign_pulse: assert property (
        op_ignored |-> !core_halt ##1 !op_ignored)
        else $error("refusal pulse wrong");
    a_fetch_app: assert property (
        !boot_loader && !$past(boot_loader) && $past(NRST)
        |-> fetch_phys == $past(fetch_addr))
        else $error("application fetch translated");
    a_trig_bit: assert property (
        ctl_rdata[CTL_TRIG_BIT] == 1'b0)
        else $error("trigger bit reads set");
endmodule
`default_nettype wire

// [isp_boot_select_and_flash_guard_tb.sv]
/* Bench for the guard and its core port joined by ibg_if.
   Assumes a flash engine modelled here and SW_RST_CYCLES of 4. */
`default_nettype none
module isp_boot_select_and_flash_guard_tb
    import ibg_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, nrst = 0, ext_n = 1, hw = 0, hw2 = 0;
    logic cyc = 0, stb = 0, we = 0, ack, fl_req, fl_done = 0;
    logic [7:0] adr = 0, fl_wd, fl_rd = 0;
    logic [3:0] sel = 0;
    logic [31:0] wdat = 0, rdat, q, rng = 32418;
    logic [1:0] fl_op;
    logic [ADDR_W-1:0] fl_addr, ld = 14'h3800, iap = 14'h3400, a;
    logic [23:0] log_q[$];
    int failures = 0, checks = 0, wait_n = 0;
    logic app = 1;
    always #2.5 clk = ~clk;
    ibg_if ibg_if_inst ();
    ibg_flash_guard #(.SW_RST_CYCLES(4)) ibg_flash_guard_inst (
        .SYS_CLK(clk), .NRST(nrst), .EXT_RST_N(ext_n),
        .HW_BOOT_LOADER_OPTION(hw), .HW_BOOT_ON_EXT_RESET_OPTION(hw2),
        .LOADER_START(ld), .IAP_LOW(iap), .FL_REQ(fl_req), .FL_OP(fl_op),
        .FL_ADDR(fl_addr), .FL_WDATA(fl_wd), .FL_RDATA(fl_rd),
        .FL_DONE(fl_done), .bus(ibg_if_inst));
    ibg_core_port ibg_core_port_inst (
        .SYS_CLK(clk), .NRST(nrst), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
        .WB_DAT_O(rdat), .WB_ACK_O(ack), .bus(ibg_if_inst));
    ibg_link_sva ibg_link_sva_inst (
        .SYS_CLK(clk), .NRST(nrst), .ctl_wr(ibg_if_inst.ctl_wr),
        .ctl_wdata(ibg_if_inst.ctl_wdata),
        .ctl_rdata(ibg_if_inst.ctl_rdata), .op_trig(ibg_if_inst.op_trig),
        .op_ignored(ibg_if_inst.op_ignored),
        .core_halt(ibg_if_inst.core_halt), .core_rst(ibg_if_inst.core_rst),
        .boot_loader(ibg_if_inst.boot_loader),
        .fetch_addr(ibg_if_inst.fetch_addr),
        .fetch_phys(ibg_if_inst.fetch_phys),
        .irq_flag(ibg_if_inst.irq_flag), .irq_take(ibg_if_inst.irq_take));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // One classic cycle; stalls while the core is halted or reset
    task automatic wb(input logic [7:0] ad, input logic w,
            input logic [31:0] d);
        int n;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= ad;
        sel <= 4'hf;
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 500);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
        if (n >= 500) begin
            failures++;
            report_and_stop();
        end
    endtask
    // Flash engine: random latency, one-cycle done
    always @(posedge clk) begin
        fl_done <= 1'b0;
        if (fl_req === 1'b1 && !fl_done) begin
            if (wait_n == 0) begin
                fl_done <= 1'b1;
                log_q.push_back({fl_op, fl_addr, fl_wd});
                wait_n <= int'(rng[1:0]);
            end else begin
                wait_n <= wait_n - 1;
            end
        end
    end
    task automatic st_chk(input logic ldr);
        wb(REG_STATUS, 1'b0, 32'h0);
        check(q & 32'hf, {28'h0, 1'b0, ldr, 2'b00});
        app = !ldr;
    endtask
    task automatic fetch();
        rng = xs(rng);
        wb(REG_FETCH, 1'b1, {18'h0, rng[13:0]});
        wb(REG_FETCH, 1'b0, 32'h0);
        a = app ? rng[13:0] : rng[13:0] + ld;
        check(q[13:0], a);
    endtask
    task automatic do_op(input logic en, input logic [4:0] m,
            input logic [13:0] ad);
        logic ok;
        logic [23:0] e;
        rng = xs(rng);
        fl_rd <= rng[15:8];
        ok = en && m >= 5'h1 && m <= 5'h3 && ad <= 14'h37ff
            && !(app && ad < iap);
        wb(REG_CTL, 1'b1, {24'h0, en, 7'h0});
        wb(REG_MODE, 1'b1, {27'h0, m});
        wb(REG_ADDR, 1'b1, {18'h0, ad});
        wb(REG_DATA, 1'b1, {24'h0, rng[7:0]});
        wb(REG_IRQ, 1'b1, 32'h3);
        wb(REG_TRIG, 1'b1, 32'h1);
        wb(REG_IRQ, 1'b0, 32'h0);
        check(q[1:0], 2'b11);
        wb(REG_STATUS, 1'b0, 32'h0);
        check(q[3:0], {!ok, !app, 2'b00});
        check(log_q.size(), ok ? 1 : 0);
        if (ok && log_q.size() == 1) begin
            e = log_q.pop_front();
            check(e[23:8], {m[1:0], ad});
            if (m == MODE_PROGRAM) check(e[7:0], rng[7:0]);
        end
        log_q.delete();
        if (ok && m == MODE_READ) begin
            wb(REG_DATA, 1'b0, 32'h0);
            check(q[7:0], rng[15:8]);
        end
        wb(REG_STATUS, 1'b1, 32'h8);
    endtask
    task automatic hreset(input logic h, input logic h2);
        nrst <= 1'b0;
        hw <= h;
        hw2 <= h2;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        st_chk(h);
    endtask
    task automatic sreset(input logic [7:0] c, input logic ldr);
        wb(REG_CTL, 1'b1, {24'h0, c});
        st_chk(ldr);
        wb(REG_CTL, 1'b0, 32'h0);
        check(q[7:0], CTL_RESET);
        wb(REG_MODE, 1'b0, 32'h0);
        check(q[MODE_W-1:0], MODE_STANDBY);
    endtask
    task automatic xreset(input logic ldr);
        ext_n <= 1'b0;
        repeat (6) @(posedge clk);
        ext_n <= 1'b1;
        repeat (2) @(posedge clk);
        st_chk(ldr);
    endtask
    initial begin
        hreset(1'b0, 1'b0);
        wb(8'h20, 1'b1, 32'hff);
        wb(8'h20, 1'b0, 32'h0);
        check(q, 32'h0);
        fetch();
        rng = xs(rng);
        do_op(1'b1, MODE_PROGRAM, iap + {4'h0, rng[9:0]});
        do_op(1'b1, MODE_ERASE, 14'h0200);
        hreset(1'b1, 1'b0);
        fetch();
        for (int m = 0; m < 5; m++) begin
            rng = xs(rng);
            do_op(1'b1, 5'(m), {1'b0, rng[12:0]});
        end
        do_op(1'b0, MODE_READ, 14'h0100);
        do_op(1'b1, MODE_PROGRAM, 14'h3800);
        do_op(1'b1, MODE_PROGRAM, 14'h37ff);
        xreset(1'b0);
        fetch();
        sreset(8'he0, 1'b1);
        sreset(8'ha0, 1'b0);
        sreset(8'he0, 1'b1);
        sreset(8'h20, 1'b0);
        hreset(1'b1, 1'b1);
        sreset(8'ha0, 1'b0);
        xreset(1'b1);
        report_and_stop();
    end
endmodule
`default_nettype wire
